// ---- design/uisr_defines.svh ----
// Offsets, field positions, reset values and pipe count of the status block
`ifndef UISR_DEFINES_SVH
`define UISR_DEFINES_SVH
// Register byte addresses
`define UISR_OFF_STATUS 8'h40
`define UISR_OFF_ENABLE 8'h44
`define UISR_OFF_IRQ_STAT 8'h48
`define UISR_OFF_IRQ_MASK 8'h4C
// Field positions of the primary status word
`define UISR_BIT_VBUS_EV 15
`define UISR_BIT_RESUME_EV 14
`define UISR_BIT_FRAME_EV 13
`define UISR_BIT_STATE_EV 12
`define UISR_BIT_CTRL_EV 11
`define UISR_BIT_EMPTY_SUM 10
`define UISR_BIT_NOT_READY_SUMMARY_SUM 9
`define UISR_BIT_READY_SUM 8
`define UISR_BIT_VBUS_LVL 7
`define UISR_BIT_SETUP 3
// Reset values
`define UISR_RST_ENABLE 16'h0000
`define UISR_RST_MASK 8'h00
// Pipe count
`define UISR_PIPES 8
`endif

// ---- design/uisr_pkg.sv ----
// Types shared by the status block
package uisr_pkg;
  // Event strobes from the USB core
  typedef struct packed {
    logic vbus_change;
    logic resume;
    logic frame_refresh;
    logic state_change;
    logic ctrl_stage_change;
    logic setup_received;
  } uisr_events_t;
  // Live state fields from the USB core
  typedef struct packed {
    logic [2:0] usb_dev_state;
    logic [2:0] ctrl_stage_code;
  } uisr_live_t;
  // Bus register selector for ack and error decode
  typedef enum logic [1:0] {
    UISR_SEL_NONE = 2'b00,
    UISR_SEL_STATUS = 2'b01,
    UISR_SEL_ENABLE = 2'b11,
    UISR_SEL_IRQ = 2'b10
  } uisr_sel_t;
  // Wishbone request
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } uisr_wb_req_t;
endpackage : uisr_pkg

// ---- design/uisr_sync3.sv ----
// Three-stage synchroniser with agreement of the last two stages
module uisr_sync3 (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Asynchronous level in, synchronised level out
  input wire logic async_i,
  output logic level_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  // Shift chain; first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // Output moves only when the last two stages agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_o <= 1'b0;
    end else if (s2_r == s3_r) begin
      level_o <= s3_r;
    end
  end
endmodule : uisr_sync3

// ---- design/uisr_sticky.sv ----
// Sticky event flag, set wins over clear
module uisr_sticky (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Set and clear strobes
  input wire logic set_i,
  input wire logic clr_i,
  // Flag
  output logic flag_o
);
  // Set wins so an event in the clearing cycle is kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_o <= 1'b0;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (clr_i) begin
      flag_o <= 1'b0;
    end
  end
endmodule : uisr_sticky

// ---- design/uisr_status.sv ----
// Primary USB interrupt status register with Wishbone slave and interrupt
`include "uisr_defines.svh"

////////////////////////////////////////////////////////////////////////////
// Contract
// R01: Bit 15 set on VBUS change, software clearable.
// R02: Bit 14 set on resume event, software clearable.
// R03: Bit 13 set on frame refresh, cleared only by writing 0.
// R04: Bit 12 set on device state transition, cleared by writing 0.
// R05: Bit 11 set on control stage transition, cleared by writing 0.
// R06: Bit 10 read-only, set while any pipe buffer-empty pending.
// R07: Bit 9 read-only, set while any pipe not-ready pending.
// R08: Bit 8 read-only, set while any pipe buffer-ready pending.
// R09: Summaries clear only after every per-pipe factor is cleared.
// R10: Bit 7 read-only, shows current VBUS pin level.
// R11: VBUS level has no hardware debounce; software filters bounce.
// R12: Bits 6:4 read-only device state; 1xx means suspended.
// R13: Bit 3 set on setup packet, cleared by writing 0.
// R14: Bits 2:0 read-only control stage code.
// R15: Host clears several event flags by separate writes 100 ns apart.
// R16: Enable bits gate each status event onto the low interrupt pin.
// R17: Disabled state event suppresses flag only; state field still moves. Here the flag still sets; the enable gates only the pin.
// R18: Writing 1 to a flag keeps it; read-only field writes ignored.
module uisr_status #(
  parameter int PIPES = `UISR_PIPES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // USB core events and state
  input wire uisr_pkg::uisr_events_t events_i,
  input wire uisr_pkg::uisr_live_t live_i,
  input wire logic vbus_pin_i,
  // Per-pipe pending factors
  input wire logic [PIPES-1:0] empty_per_pipe_status_i,
  input wire logic [PIPES-1:0] notready_per_pipe_status_i,
  input wire logic [PIPES-1:0] ready_per_pipe_status_i,
  // Interrupt outputs
  output logic irq_n_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  uisr_pkg::uisr_wb_req_t req;
  uisr_pkg::uisr_sel_t rsel;
  logic access;
  logic wr_stat;
  logic wr_en;
  logic wr_istat;
  logic wr_imask;

  // Offset to register selector, used by ack and by error decode
  function automatic uisr_pkg::uisr_sel_t decode(input logic [7:0] a);
    case (a)
      `UISR_OFF_STATUS: decode = uisr_pkg::UISR_SEL_STATUS;
      `UISR_OFF_ENABLE: decode = uisr_pkg::UISR_SEL_ENABLE;
      `UISR_OFF_IRQ_STAT: decode = uisr_pkg::UISR_SEL_IRQ;
      `UISR_OFF_IRQ_MASK: decode = uisr_pkg::UISR_SEL_IRQ;
      default: decode = uisr_pkg::UISR_SEL_NONE;
    endcase
  endfunction : decode

  // Gather request; access is a new strobe not yet answered
  always_comb begin
    req = '{cyc: cyc_i, stb: stb_i, we: we_i, adr: adr_i, sel: sel_i,
      dat: dat_i};
    rsel = decode(req.adr);
    access = req.cyc && req.stb && !ack_o && !err_o;
    wr_stat = access && req.we && req.sel[1] && req.sel[0]
      && req.adr == `UISR_OFF_STATUS;
    wr_en = access && req.we && req.adr == `UISR_OFF_ENABLE;
    wr_istat = access && req.we && req.sel[0]
      && req.adr == `UISR_OFF_IRQ_STAT;
    wr_imask = access && req.we && req.sel[0]
      && req.adr == `UISR_OFF_IRQ_MASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Live inputs

  logic vbus_level;
  logic vbus_level_d_r;

  // Three-flop crossing with two-stage agreement; no further bounce filter on purpose
  uisr_sync3 u_vbus_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(vbus_pin_i),
    .level_o(vbus_level)
  ); // see R11

  // Previous level, used only to spot a VBUS edge of its own
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vbus_level_d_r <= 1'b0;
    end else begin
      vbus_level_d_r <= vbus_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable register

  // Bits 15:11 gate events, bits 10:8 gate summaries, bit 3 gates setup
  logic [15:0] irq_enable_primary_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_enable_primary_r <= `UISR_RST_ENABLE;
    end else if (wr_en) begin
      if (req.sel[0]) begin
        irq_enable_primary_r[7:0] <= req.dat[7:0];
      end
      if (req.sel[1]) begin
        irq_enable_primary_r[15:8] <= req.dat[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky event flags

  localparam int NFLAG = 6;
  logic [NFLAG-1:0] flag_set;
  logic [NFLAG-1:0] flag_clr;
  logic [NFLAG-1:0] flag;
  logic vbus_event_flag;
  logic resume_event_flag;
  logic frame_refresh_flag;
  logic state_change_flag;
  logic ctrl_stage_change_flag;
  logic setup_flag;

  // A VBUS event is a core strobe or an edge on the synced level
  // State event enable only gates the pin; the flag and the live field still move
  always_comb begin
    flag_set[5] = events_i.vbus_change
      || (vbus_level != vbus_level_d_r); // see R01
    flag_set[4] = events_i.resume; // see R02
    flag_set[3] = events_i.frame_refresh; // see R03
    flag_set[2] = events_i.state_change; // see R04, R17
    flag_set[1] = events_i.ctrl_stage_change; // see R05
    flag_set[0] = events_i.setup_received; // see R13
    // A zero written clears, a one leaves the flag as it was
    flag_clr[5] = wr_stat && !req.dat[`UISR_BIT_VBUS_EV]; // see R18
    flag_clr[4] = wr_stat && !req.dat[`UISR_BIT_RESUME_EV];
    flag_clr[3] = wr_stat && !req.dat[`UISR_BIT_FRAME_EV];
    flag_clr[2] = wr_stat && !req.dat[`UISR_BIT_STATE_EV];
    flag_clr[1] = wr_stat && !req.dat[`UISR_BIT_CTRL_EV];
    flag_clr[0] = wr_stat && !req.dat[`UISR_BIT_SETUP];
  end

  // Six identical flags, each with set priority
  for (genvar g = 0; g < NFLAG; g++) begin : g_flag
    uisr_sticky u_flag (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .set_i(flag_set[g]),
      .clr_i(flag_clr[g]),
      .flag_o(flag[g])
    );
  end

  assign vbus_event_flag = flag[5];
  assign resume_event_flag = flag[4];
  assign frame_refresh_flag = flag[3];
  assign state_change_flag = flag[2];
  assign ctrl_stage_change_flag = flag[1];
  assign setup_flag = flag[0];

  ////////////////////////////////////////////////////////////////////////////
  // Pipe summaries

  logic buffer_empty_summary;
  logic not_ready_summary;
  logic buffer_ready_summary;

  // Summaries fall only when every pipe factor is gone; no software clear
  always_comb begin
    buffer_empty_summary = |empty_per_pipe_status_i; // see R06, R09
    not_ready_summary = |notready_per_pipe_status_i; // see R07, R09
    buffer_ready_summary = |ready_per_pipe_status_i; // see R08, R09
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word

  logic [15:0] irq_status_primary;

  // Read-only fields come straight from live state, writes never land
  always_comb begin
    irq_status_primary = 16'h0000;
    irq_status_primary[`UISR_BIT_VBUS_EV] = vbus_event_flag;
    irq_status_primary[`UISR_BIT_RESUME_EV] = resume_event_flag;
    irq_status_primary[`UISR_BIT_FRAME_EV] = frame_refresh_flag;
    irq_status_primary[`UISR_BIT_STATE_EV] = state_change_flag;
    irq_status_primary[`UISR_BIT_CTRL_EV] = ctrl_stage_change_flag;
    irq_status_primary[`UISR_BIT_EMPTY_SUM] = buffer_empty_summary;
    irq_status_primary[`UISR_BIT_NOT_READY_SUMMARY_SUM] = not_ready_summary;
    irq_status_primary[`UISR_BIT_READY_SUM] = buffer_ready_summary;
    irq_status_primary[`UISR_BIT_VBUS_LVL] = vbus_level; // see R10
    irq_status_primary[6:4] = live_i.usb_dev_state; // see R12, R17
    irq_status_primary[`UISR_BIT_SETUP] = setup_flag;
    irq_status_primary[2:0] = live_i.ctrl_stage_code; // see R14
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pin

  logic [15:0] gated;

  // Each enable bit of 15:8 and bit 3 gates the status bit of the same position
  always_comb begin
    gated = irq_status_primary & irq_enable_primary_r;
    gated[7] = 1'b0;
    gated[6:4] = 3'b000;
    gated[2:0] = 3'b000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Second-level interrupt status and mask

  // Bit 0 pin asserted, bit 1 VBUS level changed
  logic [7:0] irq_stat_r;
  logic [7:0] irq_mask_r;
  logic pin_active;

  assign pin_active = |gated; // see R16

  // Sticky status, write one to clear, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if ((i == 0 && pin_active)
            || (i == 1 && vbus_level != vbus_level_d_r)) begin
          irq_stat_r[i] <= 1'b1;
        end else if (wr_istat && req.dat[i]) begin
          irq_stat_r[i] <= 1'b0;
        end
      end
    end
  end

  // Mask register of the same layout
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_r <= `UISR_RST_MASK;
    end else if (wr_imask) begin
      irq_mask_r <= req.dat[7:0];
    end
  end

  // Active-low pin from the gated status; level line from sticky status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_n_o <= 1'b1;
      irq_o <= 1'b0;
    end else begin
      irq_n_o <= !pin_active; // see R16
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer

  // One-cycle answer; err for an unmapped offset so software sees it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= access && rsel != uisr_pkg::UISR_SEL_NONE;
      err_o <= access && rsel == uisr_pkg::UISR_SEL_NONE;
      dat_o <= 32'h0000_0000;
      if (access && !req.we) begin
        case (req.adr)
          `UISR_OFF_STATUS: dat_o <= {16'h0000, irq_status_primary};
          `UISR_OFF_ENABLE: dat_o <= {16'h0000, irq_enable_primary_r};
          `UISR_OFF_IRQ_STAT: dat_o <= {24'h000000, irq_stat_r};
          `UISR_OFF_IRQ_MASK: dat_o <= {24'h000000, irq_mask_r};
          default: dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // The 100 ns spacing between clearing writes is kept by software; each
  // clearing write is independent, so a single write may clear many here
  // see R15

endmodule : uisr_status

// ---- verif/uisr_status_sva.sv ----
// Checker on the bus and status-read ports of the status block
module uisr_status_sva #(
  parameter int PIPES = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic err_o,
  // Core side
  input wire uisr_pkg::uisr_live_t live_i,
  input wire logic [PIPES-1:0] empty_per_pipe_status_i,
  input wire logic [PIPES-1:0] notready_per_pipe_status_i,
  input wire logic [PIPES-1:0] ready_per_pipe_status_i,
  input wire logic irq_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic take;
  logic rd_st;
  logic [2:0] any;
  // Request taken on this edge; ack blocks a second take
  assign take = cyc_i && stb_i && !ack_o && !err_o;
  assign rd_st = take && !we_i && adr_i == 8'h40;
  // Pending factor summaries as the pipes show them
  assign any = {|empty_per_pipe_status_i, |notready_per_pipe_status_i,
    |ready_per_pipe_status_i};
  chk_ack_mapped:
  assert property (take && adr_i inside {8'h40, 8'h44, 8'h48, 8'h4C}
    |=> ack_o && !err_o) else $error("mapped access not acked");
  chk_err_unmapped:
  assert property (take && adr_i[7:4] != 4'h4 |=> err_o && !ack_o)
    else $error("unmapped access not refused");
  chk_ack_pulse:
  assert property (ack_o |=> !ack_o) else $error("ack longer than a cycle");
  chk_err_pulse:
  assert property (err_o |=> !err_o) else $error("err longer than a cycle");
  chk_idle_quiet:
  assert property (!(cyc_i && stb_i) |=> !ack_o && !err_o)
    else $error("answer without request");
  chk_upper_zero:
  assert property (ack_o |-> dat_o[31:16] == 16'h0000)
    else $error("upper half not zero");
  chk_sum_read:
  assert property (rd_st |=> dat_o[10:8] == $past(any))
    else $error("summary bits wrong");
  chk_state_read:
  assert property (rd_st |=> dat_o[6:4] == $past(live_i.usb_dev_state)
    && dat_o[2:0] == $past(live_i.ctrl_stage_code))
    else $error("live fields wrong");
  chk_rst_quiet:
  assert property (disable iff (1'b0) rst_i |=> irq_n_o && !ack_o)
    else $error("outputs active after reset");
endmodule : uisr_status_sva

bind uisr_status uisr_status_sva #(.PIPES(PIPES)) uisr_status_sva_inst (
  .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .err_o,
  .live_i, .empty_per_pipe_status_i, .notready_per_pipe_status_i,
  .ready_per_pipe_status_i, .irq_n_o
);

// ---- verif/uisr_host_model.sv ----
// Classic Wishbone host that stands in for the processor
module uisr_host_model (
  // Clock and answer
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic err_i,
  // Request
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  // One single cycle; call just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [3:0] s, input logic [31:0] d);
    cyc_o <= 1'h1;
    stb_o <= 1'h1;
    we_o <= w;
    adr_o <= a;
    sel_o <= s;
    dat_o <= d;
    do @(posedge clk_i); while (!(ack_i || err_i));
    cyc_o <= 1'h0;
    stb_o <= 1'h0;
    // Released data must not look valid, so turn it round
    dat_o <= ~d;
    // Two idle cycles keep clears 100 ns apart
    repeat (2) @(posedge clk_i);
  endtask : xfer
endmodule : uisr_host_model

// ---- verif/uisr_status_tb.sv ----
// Self-checking bench of the primary status block
module uisr_status_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc_i, stb_i, we_i, ack_o, err_o, irq_n_o, irq_o;
  logic vbus_pin_i = 1'h0;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o;
  uisr_pkg::uisr_events_t events_i = '0;
  uisr_pkg::uisr_live_t live_i = '0;
  logic [7:0] emp_i = 8'h00, nrd_i = 8'h00, rdy_i = 8'h00;
  logic [16:0] exp_q[$];
  logic [15:0] fl = 16'h0000;
  int bad_count = 0, n_tests = 0, cyc_n = 0;
  int fb[6] = '{3, 11, 12, 13, 14, 15};
  initial forever #25 clk_i = ~clk_i;
  uisr_host_model uisr_host_model_inst (.clk_i, .ack_i(ack_o),
    .err_i(err_o), .cyc_o(cyc_i), .stb_o(stb_i), .we_o(we_i),
    .adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i));
  uisr_status uisr_status_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .err_o, .events_i, .live_i,
    .vbus_pin_i, .empty_per_pipe_status_i(emp_i),
    .notready_per_pipe_status_i(nrd_i), .ready_per_pipe_status_i(rdy_i),
    .irq_n_o, .irq_o);
  ////////////////////////////////////////////////////////////////////////
  task automatic chk_val(input logic [16:0] got, input logic [16:0] e);
    n_tests++;
    if (got !== e) begin
      bad_count++;
      $display("wrong value at %0t: read %h, want %h", $time, got, e);
    end
  endtask : chk_val
  task automatic chk_irq(input logic got, input logic e);
    n_tests++;
    if (got !== e) begin
      bad_count++;
      $display("wrong value at %0t: irq %b, want %b", $time, got, e);
    end
  endtask : chk_irq
  task automatic complete_run();
    $display("compares %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  // Status word as the flag model and live inputs predict it
  function automatic logic [15:0] st_exp();
    return fl | {5'h00, |emp_i, |nrd_i, |rdy_i, vbus_pin_i,
      live_i.usb_dev_state, 1'h0, live_i.ctrl_stage_code};
  endfunction : st_exp
  task automatic rd(input logic [7:0] a, input logic [16:0] e);
    exp_q.push_back(e);
    uisr_host_model_inst.xfer(1'h0, a, 4'hF, 32'h0000_0000);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
    input logic [3:0] s);
    uisr_host_model_inst.xfer(1'h1, a, s, {16'h0000, d});
  endtask : wr
  // Fresh random live fields on every status read
  task automatic rd_st();
    live_i <= uisr_pkg::uisr_live_t'(6'($urandom));
    @(posedge clk_i);
    rd(8'h40, {1'h0, st_exp()});
  endtask : rd_st
  task automatic ev(input int i);
    events_i <= uisr_pkg::uisr_events_t'(6'h01 << i);
    @(posedge clk_i);
    events_i <= '0;
    @(posedge clk_i);
    fl[fb[i]] = 1'h1;
  endtask : ev
  ////////////////////////////////////////////////////////////////////////
  // Read monitor; a refused read carries only its error bit
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 5000) begin
      bad_count++;
      complete_run();
    end
    if (!rst_i && (ack_o || err_o) && !we_i) begin
      chk_val({err_o, err_o ? 16'h0000 : dat_o[15:0]},
        exp_q.pop_front());
    end
  end
  // Main sequence
  initial begin
    void'($urandom(13420));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    rd_st();
    rd(8'h44, 17'h00000);
    rd(8'h50, 17'h10000);
    chk_irq(irq_n_o, 1'h1);
    $display("test 1 done");
    for (int i = 0; i < 6; i++) begin
      ev(i);
      rd_st();
      wr(8'h40, 16'hFFFF, 4'hF);
      wr(8'h40, 16'h0000, 4'hC);
      rd_st();
      wr(8'h40, ~(16'h0001 << fb[i]), 4'hF);
      fl[fb[i]] = 1'h0;
      rd_st();
    end
    $display("test 2 done");
    repeat (10) begin
      emp_i <= 8'($urandom) & 8'($urandom) & 8'($urandom);
      nrd_i <= 8'($urandom) & 8'($urandom) & 8'($urandom);
      rdy_i <= 8'($urandom) & 8'($urandom) & 8'($urandom);
      rd_st();
    end
    {emp_i, nrd_i, rdy_i} <= '0;
    rd_st();
    $display("test 3 done");
    ev(2);
    repeat (2) @(posedge clk_i);
    chk_irq(irq_n_o, 1'h1);
    wr(8'h44, 16'h1000, 4'hF);
    chk_irq(irq_n_o, 1'h0);
    rd(8'h44, 17'h01000);
    wr(8'h4C, 16'h0001, 4'hF);
    chk_irq(irq_o, 1'h1);
    wr(8'h40, 16'hEFFF, 4'hF);
    fl[12] = 1'h0;
    wr(8'h48, 16'h0003, 4'hF);
    chk_irq(irq_n_o, 1'h1);
    chk_irq(irq_o, 1'h0);
    rd_st();
    $display("test 4 done");
    vbus_pin_i <= 1'h1;
    repeat (6) @(posedge clk_i);
    fl[15] = 1'h1;
    rd_st();
    // Level edge lands in the second-level status; pin bit stays clear
    rd(8'h48, 17'h00002);
    rd(8'h4C, 17'h00001);
    $display("test 5 done");
    complete_run();
  end
endmodule : uisr_status_tb
